// File: rtl/card_socket_interrupt_events.sv
/*
 * Card socket interrupt events: sorts socket interrupts into status
 * change events and functional requests, keeps flags and masks, and
 * drives the host interrupt onto seven multipurpose terminals.
 * Assumes all pins are synchronous to ref_clk, active high when
 * asserted, and that the power sequencer pulses power_up_done for one cycle.
 */
// Notes on behaviour
// R1: sort interrupts into status change or functional
// R2: deliver by PCI, ISA IRQ or serial
// R3: all interrupt outputs leave on seven terminals
// R4: memory card battery transitions set flags 1,0
// R5: memory card ready transition sets flag 2
// R6: io card status-change assertion sets flag 0
// R7: legacy power-up completion sets flag 3
// R8: functional request unmasked, reported at 91h bit0
// R9: wide card status-change sets socket event 0
// R10: wide card power-up completion sets event 3
// R11: card detect transitions set events 2,1
// R12: no functional request from memory cards
// R13: insertion/removal detected for any card type
// R14: shared pins read according to card type
// R15: power event comes from internal power-up
// R16: legacy flags clear by read or write-one
// R17: socket event flags clear on write-one
// R18: functional requests have no mask bit
// R19: status request held while enabled flags set
module card_socket_interrupt_events
(
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  // register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_wr_en,
  input  wire logic                          reg_rd_en,
  input  wire logic [31:0]                   reg_wdata,
  output logic      [31:0]                   reg_rdata,
  // socket pins
  input  wire socket_irq_pkg::card_kind_type card_kind,
  input  wire logic                          battery_detect_one,
  input  wire logic                          battery_detect_two,
  input  wire logic                          ready_request_line,
  input  wire logic                          card_detect_a,
  input  wire logic                          card_detect_b,
  input  wire logic                          power_up_done,
  // delivery selection
  input  wire socket_irq_pkg::scheme_type    irq_scheme,
  input  wire logic [2:0]                    status_route,
  input  wire logic [2:0]                    func_route,
  // host side
  output logic      [6:0]                    multipurpose_terminals,
  output logic                               status_request
);
  import socket_irq_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  logic [3:0] legacy_flags_q;
  logic [3:0] legacy_mask_q;
  logic [3:0] socket_flags_q;
  logic [3:0] socket_mask_q;
  logic [7:0] global_control_q;
  logic       func_flag_q;
  logic       battery_one_q;
  logic       battery_two_q;
  logic       ready_q;
  logic       detect_a_q;
  logic       detect_b_q;
  logic [2:0] slot_q;
  logic [6:0] terminals_d;
  logic [3:0] legacy_set;
  logic [3:0] socket_set;
  logic [3:0] legacy_clear;
  logic [3:0] socket_clear;
  logic       is_memory;
  logic       is_io;
  logic       is_wide;
  logic       legacy_write_clear;
  logic       func_request;

  assign is_memory = (card_kind == card_memory_type);
  assign is_io     = (card_kind == card_io_type);
  assign is_wide   = (card_kind == card_wide_type);
  assign legacy_write_clear = global_control_q[flag_clear_mode_bit];

  // previous pin levels for transition detection
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      battery_one_q <= 1'b0;
      battery_two_q <= 1'b0;
      ready_q       <= 1'b0;
      detect_a_q    <= 1'b0;
      detect_b_q    <= 1'b0;
    end else begin
      battery_one_q <= battery_detect_one;
      battery_two_q <= battery_detect_two;
      ready_q       <= ready_request_line;
      detect_a_q    <= card_detect_a;
      detect_b_q    <= card_detect_b;
    end
  end

  // ***************************************************************
  // event classification
  // ***************************************************************
  // status change events; the shared pins mean different things per card
  always_comb begin
    legacy_set = 4'h0;
    socket_set = 4'h0;
    if (is_memory) begin // see R14
      legacy_set[battery_one_bit] = battery_detect_one ^ battery_one_q; // see R4
      legacy_set[battery_two_bit] = battery_detect_two ^ battery_two_q; // see R4
      legacy_set[ready_bit]       = ready_request_line ^ ready_q; // see R5
    end
    if (is_io) begin
      legacy_set[io_status_bit] = battery_detect_one & ~battery_one_q; // see R6
    end
    if (is_wide) begin
      socket_set[wide_status_bit] = battery_detect_one & ~battery_one_q; // see R9
      socket_set[power_done_bit]  = power_up_done; // see R10
    end else begin
      legacy_set[power_done_bit] = power_up_done; // see R7, R15
    end
    // insertion and removal regardless of card kind, even an empty socket
    socket_set[detect_a_bit] = card_detect_a ^ detect_a_q; // see R11, R13
    socket_set[detect_b_bit] = card_detect_b ^ detect_b_q; // see R11, R13
  end

  // functional request only from io or wide cards, and never masked
  assign func_request = (is_io | is_wide) & ready_request_line; // see R1, R12, R18

  // ***************************************************************
  // flag clearing
  // ***************************************************************
  // legacy flags clear on read by default, by write-one when the mode bit is set; socket flags by write-one only
  always_comb begin
    legacy_clear = 4'h0;
    socket_clear = 4'h0;
    if (reg_addr == legacy_flags_offset) begin
      if (legacy_write_clear && reg_wr_en) begin
        legacy_clear = reg_wdata[3:0]; // see R16
      end else if (!legacy_write_clear && reg_rd_en) begin
        legacy_clear = 4'hf; // see R16
      end
    end
    if (reg_addr == socket_event_offset && reg_wr_en) begin
      socket_clear = reg_wdata[3:0]; // see R17
    end
  end

  // legacy flags; a set in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      legacy_flags_q <= flags_reset_value;
    end else begin
      legacy_flags_q <= (legacy_flags_q & ~legacy_clear) | legacy_set;
    end
  end

  // socket event flags, same set-wins policy
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      socket_flags_q <= flags_reset_value;
    end else begin
      socket_flags_q <= (socket_flags_q & ~socket_clear) | socket_set;
    end
  end

  // functional flag follows the request line
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      func_flag_q <= 1'b0;
    end else begin
      func_flag_q <= func_request; // see R8
    end
  end

  // ***************************************************************
  // writable registers
  // ***************************************************************
  // masks and global control
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      legacy_mask_q    <= mask_reset_value;
      socket_mask_q    <= mask_reset_value;
      global_control_q <= control_reset_value;
    end else if (reg_wr_en) begin
      if (reg_addr == legacy_mask_offset) begin
        legacy_mask_q <= reg_wdata[3:0];
      end
      if (reg_addr == socket_mask_offset) begin
        socket_mask_q <= reg_wdata[3:0];
      end
      if (reg_addr == global_control_offset) begin
        global_control_q <= reg_wdata[7:0];
      end
    end
  end

  // read data held until the next read; unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        legacy_flags_offset:   reg_rdata <= {28'h0, legacy_flags_q};
        legacy_mask_offset:    reg_rdata <= {28'h0, legacy_mask_q};
        global_control_offset: reg_rdata <= {24'h0, global_control_q};
        func_flag_offset:      reg_rdata <= {31'h0, func_flag_q}; // see R8
        socket_event_offset:   reg_rdata <= {28'h0, socket_flags_q};
        socket_mask_offset:    reg_rdata <= {28'h0, socket_mask_q};
        default:               reg_rdata <= 32'h0;
      endcase
    end
  end

  // ***************************************************************
  // delivery to the host
  // ***************************************************************
  // request stays up until every enabled flag is cleared
  assign status_request = |(legacy_flags_q & legacy_mask_q)
                        | |(socket_flags_q & socket_mask_q); // see R19

  // serial frame slot counter, free running
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      slot_q <= serial_start_slot;
    end else if (slot_q == serial_frame_last) begin
      slot_q <= serial_start_slot;
    end else begin
      slot_q <= slot_q + 3'h1;
    end
  end

  // terminal levels: PCI style is active low, ISA style active high
  always_comb begin
    terminals_d = 7'h7f;
    unique case (irq_scheme)
      scheme_pci: begin
        terminals_d[status_route] = ~status_request;
        terminals_d[func_route]   = terminals_d[func_route] & ~func_flag_q;
      end
      scheme_isa: begin
        terminals_d = 7'h00;
        terminals_d[status_route] = status_request;
        terminals_d[func_route]   = terminals_d[func_route] | func_flag_q;
      end
      scheme_pci_isa: begin
        // status on a shared PCI line, function on an ISA line
        terminals_d[func_route]   = func_flag_q;
        terminals_d[status_route] = ~status_request;
      end
      scheme_serial: begin
        // one terminal carries a fixed-slot frame; slots idle high
        if (slot_q == serial_start_slot) begin
          terminals_d[serial_terminal] = 1'b0;
        end else if (slot_q == serial_status_slot) begin
          terminals_d[serial_terminal] = ~status_request;
        end else if (slot_q == serial_func_slot) begin
          terminals_d[serial_terminal] = ~func_flag_q;
        end
      end
    endcase // see R2
  end

  // registered so the pins never glitch on mode or route changes
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      multipurpose_terminals <= 7'h7f;
    end else begin
      multipurpose_terminals <= terminals_d; // see R3
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_ready_flag;
    is_memory && (ready_request_line != ready_q) |=> legacy_flags_q[ready_bit];
  endproperty
  a_ready_flag: assert property (p_ready_flag) // see R5
    else $error("ready transition did not set flag");

  property p_detect_flag;
    card_detect_a != detect_a_q |=> socket_flags_q[detect_a_bit];
  endproperty
  a_detect_flag: assert property (p_detect_flag) // see R11
    else $error("card detect transition lost");

  property p_func_unmasked;
    is_io && ready_request_line |=> func_flag_q;
  endproperty
  a_func_unmasked: assert property (p_func_unmasked) // see R18
    else $error("functional request not reported");

  property p_memory_no_func;
    is_memory |=> !func_flag_q;
  endproperty
  a_memory_no_func: assert property (p_memory_no_func) // see R12
    else $error("memory card produced functional request");

  property p_wide_power;
    is_wide && power_up_done |=> socket_flags_q[power_done_bit] && !$rose(legacy_flags_q[power_done_bit]);
  endproperty
  a_wide_power: assert property (p_wide_power) // see R10
    else $error("wide power event misrouted");

  property p_socket_w1c;
    reg_wr_en && reg_addr == socket_event_offset && reg_wdata[0] && !socket_set[0]
      |=> !socket_flags_q[0];
  endproperty
  a_socket_w1c: assert property (p_socket_w1c) // see R17
    else $error("socket flag not cleared by write one");

  property p_read_clear;
    reg_rd_en && reg_addr == legacy_flags_offset && !legacy_write_clear && legacy_set == 4'h0
      |=> legacy_flags_q == 4'h0;
  endproperty
  a_read_clear: assert property (p_read_clear) // see R16
    else $error("legacy flags not cleared on read");
  property p_hold_request;
    status_request && legacy_clear == 4'h0 && socket_clear == 4'h0
      && !(reg_wr_en && (reg_addr == legacy_mask_offset || reg_addr == socket_mask_offset)) |=> status_request;
  endproperty
  a_hold_request: assert property (p_hold_request) // see R19
    else $error("status request dropped without clear");
  property p_isa_pin;
    irq_scheme == scheme_isa && status_request |=> multipurpose_terminals[$past(status_route)];
  endproperty
  a_isa_pin: assert property (p_isa_pin) // see R2
    else $error("status request missing on terminal");

endmodule : card_socket_interrupt_events

// File: rtl/socket_irq_pkg.sv
/*
 * Constants and types for the card socket interrupt event block.
 * Assumes a single 20 MHz clock and a synchronous, active-low reset.
 */
package socket_irq_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0] legacy_flags_offset   = 8'h04;
  localparam logic [7:0] legacy_mask_offset    = 8'h05;
  localparam logic [7:0] global_control_offset = 8'h1e;
  localparam logic [7:0] func_flag_offset      = 8'h91;
  localparam logic [7:0] socket_event_offset   = 8'ha0;
  localparam logic [7:0] socket_mask_offset    = 8'ha4;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int battery_one_bit     = 0;
  localparam int battery_two_bit     = 1;
  localparam int ready_bit           = 2;
  localparam int power_done_bit      = 3;
  localparam int io_status_bit       = 0;
  localparam int wide_status_bit     = 0;
  localparam int detect_a_bit        = 1;
  localparam int detect_b_bit        = 2;
  localparam int func_request_bit    = 0;
  localparam int flag_clear_mode_bit = 2;

  // ***************************************************************
  // reset values and serial frame
  // ***************************************************************
  localparam logic [3:0] flags_reset_value   = 4'h0;
  localparam logic [3:0] mask_reset_value    = 4'h0;
  localparam logic [7:0] control_reset_value = 8'h00;
  localparam logic [2:0] serial_frame_last   = 3'h7;
  localparam logic [2:0] serial_start_slot   = 3'h0;
  localparam logic [2:0] serial_status_slot  = 3'h1;
  localparam logic [2:0] serial_func_slot    = 3'h2;
  localparam logic [2:0] serial_terminal     = 3'h6;

  typedef enum logic [1:0] {
    card_none_type,
    card_memory_type,
    card_io_type,
    card_wide_type
  } card_kind_type;

  typedef enum logic [1:0] {
    scheme_pci,
    scheme_isa,
    scheme_pci_isa,
    scheme_serial
  } scheme_type;

endpackage : socket_irq_pkg

// File: sim/socket_side_model.sv
/*
 * Card side of the socket: card kind, shared pins and the internal
 * power sequencer pulse. Assumes the bench calls its tasks in order.
 */
module socket_side_model
  import socket_irq_pkg::*;
(
  // clock
  input  wire logic                          ref_clk,
  // socket pins
  output socket_irq_pkg::card_kind_type      card_kind,
  output logic                               battery_detect_one,
  output logic                               battery_detect_two,
  output logic                               ready_request_line,
  output logic                               card_detect_a,
  output logic                               card_detect_b,
  output logic                               power_up_done
);
  timeunit 1ns;
  timeprecision 100ps;

  // ***************************************************************
  // pin levels
  // ***************************************************************
  logic [4:0] pins;

  // one vector so the bench can address lines by index
  assign battery_detect_one = pins[0];
  assign battery_detect_two = pins[1];
  assign ready_request_line = pins[2];
  assign card_detect_a      = pins[3];
  assign card_detect_b      = pins[4];

  initial begin
    pins          = 5'h00;
    card_kind     = card_none_type;
    power_up_done = 1'b0;
  end

  // changes land just after an edge, never on it
  task set_kind(input card_kind_type k);
    @(posedge ref_clk);
    #2;
    card_kind = k;
  endtask : set_kind

  task set_pin(input int idx, input logic lvl);
    @(posedge ref_clk);
    #2;
    pins[idx] = lvl;
  endtask : set_pin

  // one-cycle pulse: the sequencer, not a card pin, ends power-up
  task pulse_power;
    @(posedge ref_clk);
    #2;
    power_up_done = 1'b1;
    @(posedge ref_clk);
    #2;
    power_up_done = 1'b0;
  endtask : pulse_power
endmodule : socket_side_model

// File: sim/card_socket_interrupt_events_bench.sv
/*
 * Self-checking bench for the socket interrupt event block.
 * Assumes the design package and the socket side model are compiled first.
 */
module card_socket_interrupt_events_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import socket_irq_pkg::*;

  // ***************************************************************
  // signals
  // ***************************************************************
  logic          ref_clk = 1'b0;
  logic          reset_n = 1'b0;
  logic [7:0]    reg_addr = 8'h00;
  logic          reg_wr_en = 1'b0;
  logic          reg_rd_en = 1'b0;
  logic [31:0]   reg_wdata = 32'h0;
  logic [31:0]   reg_rdata;
  card_kind_type card_kind;
  logic          bat_one, bat_two, ready_req, det_a, det_b, power_done;
  scheme_type    irq_scheme = scheme_pci;
  logic [2:0]    status_route = 3'h2;
  logic [2:0]    func_route = 3'h5;
  logic [6:0]    terms;
  logic          status_request;
  int            failures = 0;
  int            checks_done = 0;
  logic [31:0]   rd_val;
  logic [7:0]    offs [6] = '{8'h04, 8'h05, 8'h1e, 8'h91, 8'ha0, 8'ha4};

  always #25 ref_clk = ~ref_clk;

  socket_side_model sock (.ref_clk(ref_clk), .card_kind(card_kind), .battery_detect_one(bat_one),
    .battery_detect_two(bat_two), .ready_request_line(ready_req), .card_detect_a(det_a),
    .card_detect_b(det_b), .power_up_done(power_done));

  card_socket_interrupt_events dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .card_kind(card_kind), .battery_detect_one(bat_one), .battery_detect_two(bat_two),
    .ready_request_line(ready_req), .card_detect_a(det_a), .card_detect_b(det_b),
    .power_up_done(power_done), .irq_scheme(irq_scheme), .status_route(status_route),
    .func_route(func_route), .multipurpose_terminals(terms), .status_request(status_request));

  // ***************************************************************
  // access and compare tasks
  // ***************************************************************
  task check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_reg

  task check_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_bit

  // strobe lasts one cycle; data lands on the following edge
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    #2;
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(posedge ref_clk);
    #2;
    reg_rd_en = 1'b0;
    d         = reg_rdata;
  endtask : rd

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    #2;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #2;
    reg_wr_en = 1'b0;
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd_val);
    check_reg(rd_val, exp, "register read");
  endtask : rd_chk

  task idle(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : idle

  // move one pin, let the flag settle, then read it back
  task ev(input int idx, input logic lvl, input logic [7:0] a, input logic [31:0] exp);
    sock.set_pin(idx, lvl);
    idle(3);
    rd_chk(a, exp);
  endtask : ev

  // low slots on the serial terminal over one whole frame, any phase
  task frame_lows(input int exp);
    int lows;
    lows = 0;
    repeat (serial_frame_last + 1) begin
      @(posedge ref_clk);
      #2;
      lows += (terms[serial_terminal] === 1'b0);
    end
    check_reg(lows, exp, "serial low slots");
  endtask : frame_lows

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // hang guard: the tests need well under a thousand cycles
  initial begin
    #150000;
    failures++;
    close_out();
  end

  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    idle(8);
    reset_n = 1'b1;
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    check_bit(status_request, 1'b0, "request after reset");
    check_reg({25'h0, terms}, 32'h7f, "terminals idle");
    wr(8'h33, 32'hff);
    rd_chk(8'h33, 32'h0);
    wr(8'h91, 32'h1);
    rd_chk(8'h91, 32'h0);
    wr(8'h05, 32'hf);
    rd_chk(8'h05, 32'hf);
    wr(8'ha4, 32'hf);
    rd_chk(8'ha4, 32'hf);
    // an empty socket still reports insertion and removal
    ev(3, 1'b1, 8'ha0, 32'h2);
    wr(8'ha0, 32'h2);
    ev(3, 1'b0, 8'ha0, 32'h2);
    wr(8'ha0, 32'h2);
    // memory card: every edge of battery and ready counts
    sock.set_kind(card_memory_type);
    ev(0, 1'b1, 8'h04, 32'h1);
    ev(0, 1'b0, 8'h04, 32'h1);
    ev(1, 1'b1, 8'h04, 32'h2);
    ev(1, 1'b0, 8'h04, 32'h2);
    ev(2, 1'b1, 8'h04, 32'h4);
    rd_chk(8'h91, 32'h0);
    sock.set_pin(2, 1'b0);
    idle(3);
    check_bit(status_request, 1'b1, "request pending");
    check_bit(terms[2], 1'b0, "low-active status line");
    rd_chk(8'h04, 32'h4);
    idle(2);
    check_bit(status_request, 1'b0, "request dropped");
    check_bit(terms[2], 1'b1, "status line released");
    // io card: status change, request and power-up
    sock.set_kind(card_io_type);
    ev(0, 1'b1, 8'h04, 32'h1);
    ev(0, 1'b0, 8'h04, 32'h0);
    irq_scheme = scheme_isa;
    wr(8'h05, 32'h0);
    ev(2, 1'b1, 8'h91, 32'h1);
    check_bit(terms[5], 1'b1, "unmasked request line");
    rd_chk(8'h04, 32'h0);
    ev(2, 1'b0, 8'h91, 32'h0);
    sock.pulse_power();
    idle(3);
    check_bit(status_request, 1'b0, "masked flag held off");
    rd_chk(8'h04, 32'h8);
    ev(3, 1'b1, 8'ha0, 32'h2);
    wr(8'ha0, 32'h2);
    rd_chk(8'ha0, 32'h0);
    // wide card: socket events
    sock.set_kind(card_wide_type);
    ev(4, 1'b1, 8'ha0, 32'h4);
    ev(0, 1'b1, 8'ha0, 32'h5);
    sock.pulse_power();
    idle(3);
    rd_chk(8'ha0, 32'hd);
    check_bit(status_request, 1'b1, "socket request");
    wr(8'ha0, 32'h5);
    rd_chk(8'ha0, 32'h8);
    rd_chk(8'h04, 32'h0);
    wr(8'ha0, 32'h8);
    ev(2, 1'b1, 8'h91, 32'h1);
    // combined and serial delivery with both kinds of request pending
    irq_scheme = scheme_pci_isa;
    sock.set_pin(3, 1'b0);
    idle(3);
    check_bit(terms[5], 1'b1, "active-high function line");
    check_bit(terms[2], 1'b0, "active-low status line");
    irq_scheme = scheme_serial;
    frame_lows(3);
    sock.set_pin(0, 1'b0);
    sock.set_pin(2, 1'b0);
    wr(8'ha0, 32'h2);
    frame_lows(1);
    // write-one clear mode on the legacy flags
    sock.set_kind(card_memory_type);
    wr(8'h1e, 32'h4);
    rd_chk(8'h1e, 32'h4);
    ev(1, 1'b1, 8'h04, 32'h2);
    rd_chk(8'h04, 32'h2);
    wr(8'h04, 32'h2);
    rd_chk(8'h04, 32'h0);
    close_out();
  end
endmodule : card_socket_interrupt_events_bench
